// ==== pkg/wdog_pkg.sv ====
`default_nettype none
package wdog_pkg;
  // ****************************************
  // Time base
  // ****************************************
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned MS_W = 21;
  localparam int unsigned WD_PERIOD_MIN_MS = 1;
  localparam int unsigned WD_PERIOD_MAX_MS = 258048;
  localparam int unsigned START_BASE_MS = 100;
  localparam logic [3:0] START_SEL_MAX = 4'hF;
  localparam logic [4:0] DELAY_SEL_MAX = 5'h10;
  localparam int unsigned PULSE_MIN_MS = 1;
  localparam int unsigned PULSE_MAX_MS = 32256;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_PULSE = 8'h08;
  localparam logic [7:0] OFS_RAIL = 8'h0C;
  localparam logic [7:0] OFS_GPI = 8'h10;
  localparam logic [7:0] OFS_KICK = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  localparam int unsigned CTRL_WD_EN = 0;
  localparam int unsigned CTRL_PULSE_MODE = 1;
  localparam int unsigned CTRL_TO_RESET = 2;
  localparam int unsigned CTRL_TRACK = 3;
  localparam int unsigned CTRL_START_LSB = 8;
  localparam int unsigned CTRL_DELAY_LSB = 16;
  localparam int unsigned IRQ_TIMEOUT = 0;
  localparam int unsigned IRQ_ASSERT = 1;
  localparam int unsigned IRQ_RELEASE = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [17:0] PERIOD_RST = 18'h003E8;
  localparam logic [14:0] PULSE_RST = 15'h0064;
  localparam logic [23:0] RAIL_RST = 24'h00_0000;
  localparam logic [7:0] GPI_RST = 8'h00;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ****************************************
  // States
  // ****************************************
  typedef enum logic [3:0] {
    WD_OFF = 4'h1,
    WD_WAIT = 4'h2,
    WD_RUN = 4'h4,
    WD_TO = 4'h8
  } wd_state_e;

  typedef enum logic [5:0] {
    RS_HOLD = 6'h01,
    RS_DELAY = 6'h02,
    RS_RUN = 6'h04,
    RS_ARM = 6'h08,
    RS_PULSE = 6'h10,
    RS_WDREL = 6'h20
  } rs_state_e;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [MS_W-1:0] start_wait_ms(input logic [3:0] sel);
    start_wait_ms = MS_W'(START_BASE_MS) << (sel - 4'h1);
  endfunction

  function automatic logic [MS_W-1:0] delay_ms(input logic [4:0] sel);
    if (sel == 5'h00)
    begin
      delay_ms = '0;
    end
    else
    begin
      delay_ms = MS_W'(1) << (sel - 5'h01);
    end
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
    begin
      old[i*8 +: 8] = strb[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
    strb_merge = old;
  endfunction
endpackage
`default_nettype wire

// ==== pkg/tick_if.sv ====
`default_nettype none
interface tick_if;
  logic ms_tick;
  modport src (output ms_tick);
  modport dst (input ms_tick);
endinterface
`default_nettype wire

// ==== hdl/tick_gen.sv ====
`default_nettype none
module tick_gen
  import wdog_pkg::*;
#(
  parameter int unsigned DIV = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Millisecond enable
  tick_if.src tk
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb
  begin
    tick_nxt = 1'b0;
    cnt_nxt = cnt_r + 32'h0000_0001;
    if (cnt_r >= DIV - 1)
    begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tk.ms_tick = tick_r;
endmodule
`default_nettype wire

// ==== hdl/watchdog_and_system_reset.sv ====
// Summary of operation
// - Each keepalive toggle from the processor restarts the supervision count from zero.
// - Without a toggle inside the period the block times out and pulses timeout_output.
// - A keepalive command written over the register bus counts the same as a pin toggle.
// - The supervision period is programmable from 0.001 s to 258.048 s.
// - After a timeout supervision restarts on a pin toggle or a keepalive command.
// - Supervision starts at once or after a wait of 100 ms doubling up to 1638.4 s.
// - The timeout goes either to the logic output or into the system reset.
// - Reset releases once selected rails are power good, selected inputs set, and delay over.
// - The release delay is 0 ms or 1 ms doubling per step up to 32.768 s.
// - In level mode reset asserts at once when a selected rail or input goes bad.
// - In pulse mode one reset pulse of 0.001 s to 32.256 s follows power good on.
// - A watchdog timeout toggles reset, released by fixed delay or input tracking.
// - Reset leaves power-up asserted.
// - Reconfiguring the reset function asserts reset before re-evaluating conditions.
`default_nettype none
module watchdog_and_system_reset
  import wdog_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Supervised system
  input wire logic keepalive_input,
  input wire logic [7:0] general_input,
  input wire logic [23:0] rail_pg_on,
  input wire logic [23:0] rail_below_pg_off,
  output logic timeout_output,
  output logic logic_output,
  output logic system_reset_n,
  output logic system_reset_oe,
  output logic irq
);
  tick_if tk ();
  tick_gen #(.DIV(TICK_DIV)) u_tick (.aclk(aclk), .aresetn(aresetn), .tk(tk));

  // ****************************************
  // State
  // ****************************************
  logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt, rdata_r, rdata_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [17:0] period_r, period_nxt;
  logic [14:0] pulse_r, pulse_nxt;
  logic [23:0] rail_r, rail_nxt;
  logic [7:0] gpi_r, gpi_nxt;
  logic [2:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
  logic irq_r, irq_nxt, kick_r, kick_nxt, reconf_r, reconf_nxt;
  logic ka_s1_r, ka_s2_r, ka_s3_r;
  wd_state_e wd_r, wd_nxt;
  logic [MS_W-1:0] wd_cnt_r, wd_cnt_nxt;
  logic wd_evt_r, wd_evt_nxt, to_out_r, to_out_nxt, lo_r, lo_nxt;
  rs_state_e rs_r, rs_nxt;
  logic [MS_W-1:0] rs_cnt_r, rs_cnt_nxt;
  logic rst_n_r, rst_n_nxt, rst_oe_r;
  logic ka_edge, kick, cond_ok, cond_bad;
  logic [MS_W-1:0] dly, pw, per;

  assign ka_edge = ka_s2_r ^ ka_s3_r;
  assign kick = ka_edge | kick_r;
  assign dly = delay_ms(ctrl_r[CTRL_DELAY_LSB +: 5]);
  assign pw = {6'h00, pulse_r};
  assign per = {3'h0, period_r};
  assign cond_ok = (&(rail_pg_on | ~rail_r)) && (&(general_input | ~gpi_r));
  assign cond_bad = (|(rail_below_pg_off & rail_r)) || (|(~general_input & gpi_r));

  // ****************************************
  // Register bus and register file
  // ****************************************
  always_comb
  begin
    logic [31:0] wv;
    logic [2:0] evt;
    wv = strb_merge(32'h0000_0000, w_data_r, w_strb_r);
    evt = {~rst_n_r & rst_n_nxt, rst_n_r & ~rst_n_nxt, wd_evt_r};
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    ctrl_nxt = ctrl_r;
    period_nxt = period_r;
    pulse_nxt = pulse_r;
    rail_nxt = rail_r;
    gpi_nxt = gpi_r;
    irq_mask_nxt = irq_mask_r;
    kick_nxt = 1'b0;
    reconf_nxt = 1'b0;
    irq_stat_nxt = irq_stat_r;
    if (awvalid && awready_r)
    begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = awaddr;
      awready_nxt = 1'b0;
    end
    if (wvalid && wready_r)
    begin
      w_hold_nxt = 1'b1;
      w_data_nxt = wdata;
      w_strb_nxt = wstrb;
      wready_nxt = 1'b0;
    end
    if (aw_hold_r && w_hold_r && !bvalid_r)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      unique case (aw_addr_r)
        OFS_CTRL:
        begin
          ctrl_nxt = strb_merge(ctrl_r, w_data_r, w_strb_r);
          if (ctrl_nxt[CTRL_DELAY_LSB +: 5] > DELAY_SEL_MAX)
          begin
            ctrl_nxt[CTRL_DELAY_LSB +: 5] = DELAY_SEL_MAX;
          end
          reconf_nxt = 1'b1;
        end
        OFS_PERIOD:
        begin
          period_nxt = strb_merge({14'h0000, period_r}, w_data_r, w_strb_r) > WD_PERIOD_MAX_MS
                       ? 18'(WD_PERIOD_MAX_MS) : wv[17:0];
          if (period_nxt == 18'h00000)
          begin
            period_nxt = 18'(WD_PERIOD_MIN_MS);
          end
        end
        OFS_PULSE:
        begin
          pulse_nxt = wv > PULSE_MAX_MS ? 15'(PULSE_MAX_MS) : wv[14:0];
          if (pulse_nxt == 15'h0000)
          begin
            pulse_nxt = 15'(PULSE_MIN_MS);
          end
          reconf_nxt = 1'b1;
        end
        OFS_RAIL:
        begin
          rail_nxt = wv[23:0];
          reconf_nxt = 1'b1;
        end
        OFS_GPI:
        begin
          gpi_nxt = wv[7:0];
          reconf_nxt = 1'b1;
        end
        OFS_KICK: kick_nxt = wv[0];
        OFS_STATUS: bresp_nxt = RESP_OKAY;
        OFS_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~wv[2:0];
        OFS_IRQ_MASK: irq_mask_nxt = wv[2:0];
        default: bresp_nxt = RESP_DECERR;
      endcase
    end
    // A new event outranks a clear in the same cycle
    irq_stat_nxt = irq_stat_nxt | evt;
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
    if (bvalid_r && bready)
    begin
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end
    if (arvalid && arready_r)
    begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      unique case (araddr)
        OFS_CTRL: rdata_nxt = ctrl_r;
        OFS_PERIOD: rdata_nxt = {14'h0000, period_r};
        OFS_PULSE: rdata_nxt = {17'h00000, pulse_r};
        OFS_RAIL: rdata_nxt = {8'h00, rail_r};
        OFS_GPI: rdata_nxt = {24'h00_0000, gpi_r};
        OFS_KICK: rdata_nxt = 32'h0000_0000;
        OFS_STATUS: rdata_nxt = {20'h00000, to_out_r, rst_n_r, rs_r, wd_r};
        OFS_IRQ_STAT: rdata_nxt = {29'h0000_0000, irq_stat_r};
        OFS_IRQ_MASK: rdata_nxt = {29'h0000_0000, irq_mask_r};
        default:
        begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_DECERR;
        end
      endcase
    end
    else if (rvalid_r && rready)
    begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  // ****************************************
  // Supervision timer
  // ****************************************
  always_comb
  begin
    wd_nxt = wd_r;
    wd_cnt_nxt = wd_cnt_r;
    wd_evt_nxt = 1'b0;
    // Pin pulse lasts until the next millisecond tick
    to_out_nxt = to_out_r & ~tk.ms_tick;
    if (!ctrl_r[CTRL_WD_EN])
    begin
      wd_nxt = WD_OFF;
      wd_cnt_nxt = '0;
    end
    else
    begin
      unique case (wd_r)
        WD_OFF:
        begin
          wd_cnt_nxt = '0;
          wd_nxt = ctrl_r[CTRL_START_LSB +: 4] == 4'h0 ? WD_RUN : WD_WAIT;
        end
        WD_WAIT:
        begin
          if (tk.ms_tick)
          begin
            wd_cnt_nxt = wd_cnt_r + 21'h000001;
            if (wd_cnt_nxt >= start_wait_ms(ctrl_r[CTRL_START_LSB +: 4]))
            begin
              wd_nxt = WD_RUN;
              wd_cnt_nxt = '0;
            end
          end
        end
        WD_RUN:
        begin
          if (kick)
          begin
            wd_cnt_nxt = '0;
          end
          else if (tk.ms_tick)
          begin
            wd_cnt_nxt = wd_cnt_r + 21'h000001;
            if (wd_cnt_nxt >= per)
            begin
              wd_nxt = WD_TO;
              wd_cnt_nxt = '0;
              wd_evt_nxt = 1'b1;
              to_out_nxt = 1'b1;
            end
          end
        end
        WD_TO:
        begin
          if (kick)
          begin
            wd_nxt = WD_RUN;
            wd_cnt_nxt = '0;
          end
        end
      endcase
    end
    lo_nxt = to_out_nxt & ~ctrl_r[CTRL_TO_RESET];
  end

  // ****************************************
  // System reset sequencer
  // ****************************************
  always_comb
  begin
    rs_nxt = rs_r;
    rs_cnt_nxt = rs_cnt_r;
    if (reconf_r)
    begin
      // Pulls reset low for at least a cycle even if release holds
      rs_nxt = RS_HOLD;
      rs_cnt_nxt = '0;
    end
    else
    begin
      unique case (rs_r)
        RS_HOLD:
        begin
          rs_cnt_nxt = '0;
          if (cond_ok)
          begin
            if (ctrl_r[CTRL_PULSE_MODE])
            begin
              rs_nxt = RS_PULSE;
            end
            else
            begin
              rs_nxt = dly == '0 ? RS_RUN : RS_DELAY;
            end
          end
        end
        RS_DELAY:
        begin
          if (cond_bad)
          begin
            rs_nxt = RS_HOLD;
          end
          else if (tk.ms_tick)
          begin
            rs_cnt_nxt = rs_cnt_r + 21'h000001;
            if (rs_cnt_nxt >= dly)
            begin
              rs_nxt = RS_RUN;
            end
          end
        end
        RS_RUN:
        begin
          rs_cnt_nxt = '0;
          if (wd_evt_r && ctrl_r[CTRL_TO_RESET])
          begin
            rs_nxt = RS_WDREL;
          end
          else if (cond_bad)
          begin
            rs_nxt = ctrl_r[CTRL_PULSE_MODE] ? RS_ARM : RS_HOLD;
          end
        end
        RS_ARM:
        begin
          rs_cnt_nxt = '0;
          if (cond_ok)
          begin
            rs_nxt = RS_PULSE;
          end
        end
        RS_PULSE:
        begin
          if (tk.ms_tick)
          begin
            rs_cnt_nxt = rs_cnt_r + 21'h000001;
            if (rs_cnt_nxt >= pw)
            begin
              rs_nxt = RS_RUN;
              rs_cnt_nxt = '0;
            end
          end
        end
        RS_WDREL:
        begin
          if (tk.ms_tick)
          begin
            rs_cnt_nxt = rs_cnt_r + 21'h000001;
            if (rs_cnt_nxt >= pw)
            begin
              rs_cnt_nxt = '0;
              // Tracking waits for the inputs again; fixed release only times the delay
              if (ctrl_r[CTRL_TRACK])
              begin
                rs_nxt = RS_HOLD;
              end
              else
              begin
                rs_nxt = dly == '0 ? RS_RUN : RS_DELAY;
              end
            end
          end
        end
      endcase
    end
    rst_n_nxt = (rs_nxt == RS_RUN) || (rs_nxt == RS_ARM);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      ctrl_r <= CTRL_RST;
      period_r <= PERIOD_RST;
      pulse_r <= PULSE_RST;
      rail_r <= RAIL_RST;
      gpi_r <= GPI_RST;
      irq_stat_r <= 3'h0;
      irq_mask_r <= MASK_RST;
      irq_r <= 1'b0;
      kick_r <= 1'b0;
      reconf_r <= 1'b0;
      ka_s1_r <= 1'b0;
      ka_s2_r <= 1'b0;
      ka_s3_r <= 1'b0;
      wd_r <= WD_OFF;
      wd_cnt_r <= '0;
      wd_evt_r <= 1'b0;
      to_out_r <= 1'b0;
      lo_r <= 1'b0;
      rs_r <= RS_HOLD;
      rs_cnt_r <= '0;
      rst_n_r <= 1'b0;
      rst_oe_r <= 1'b1;
    end
    else
    begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      ctrl_r <= ctrl_nxt;
      period_r <= period_nxt;
      pulse_r <= pulse_nxt;
      rail_r <= rail_nxt;
      gpi_r <= gpi_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_r <= irq_nxt;
      kick_r <= kick_nxt;
      reconf_r <= reconf_nxt;
      ka_s1_r <= keepalive_input;
      ka_s2_r <= ka_s1_r;
      ka_s3_r <= ka_s2_r;
      wd_r <= wd_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      wd_evt_r <= wd_evt_nxt;
      to_out_r <= to_out_nxt;
      lo_r <= lo_nxt;
      rs_r <= rs_nxt;
      rs_cnt_r <= rs_cnt_nxt;
      rst_n_r <= rst_n_nxt;
      rst_oe_r <= 1'b1;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign timeout_output = to_out_r;
  assign logic_output = lo_r;
  assign system_reset_n = rst_n_r;
  assign system_reset_oe = rst_oe_r;
  assign irq = irq_r;
endmodule
`default_nettype wire

// ==== sim/keepalive_host.sv ====
`default_nettype none
module keepalive_host
(
  // Clock
  input wire logic aclk,
  // Bench control
  input wire logic run,
  input wire logic [7:0] gap,
  // Reset from the device
  input wire logic system_reset_n,
  // Keepalive pin
  output logic keepalive_input
);
  timeunit 1ns / 100ps;
  // ****************
  // Processor kick loop
  // ****************
  logic [7:0] cnt_r = 8'h00;
  initial keepalive_input = 1'b0;
  always @(posedge aclk)
  begin
    // A processor held in reset cannot kick
    if (!run || !system_reset_n)
      cnt_r <= 8'h00;
    else if (cnt_r >= gap)
    begin
      cnt_r <= 8'h00;
      keepalive_input <= !keepalive_input;
    end
    else
      cnt_r <= cnt_r + 8'h01;
  end
endmodule
`default_nettype wire

// ==== sim/watchdog_and_system_reset_properties.sv ====
`default_nettype none
module watchdog_and_system_reset_properties
  import wdog_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  // Supervised system
  input wire logic timeout_output,
  input wire logic logic_output,
  input wire logic system_reset_n,
  input wire logic system_reset_oe
);
  timeunit 1ns / 100ps;
  // ****************
  // Properties
  // ****************
  // The pulse ends at the next ms tick, so one tick plus a cycle bounds it
  localparam int PW = TICK_DIV + 1;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence ctrl_wr;
    wr_taken ##0 (awaddr == OFS_CTRL);
  endsequence
  write_answer_a: assert property (wr_taken |-> ##[1:2] bvalid)
    else $error("write answer late");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  bus_refused_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while answer pending");
  reset_state_a: assert property ($rose(aresetn) |-> !system_reset_n && awready)
    else $error("reset pin released at power-up");
  pin_driven_a: assert property (system_reset_oe)
    else $error("reset pin not driven");
  reconfig_low_a: assert property (ctrl_wr |-> ##[1:3] !system_reset_n)
    else $error("no reset on reconfiguration");
  timeout_pulse_a: assert property ($rose(timeout_output) |-> ##[1:PW] !timeout_output)
    else $error("timeout pulse too long");
  logic_copy_a: assert property (logic_output |-> timeout_output || $past(timeout_output))
    else $error("logic output without timeout");
endmodule
bind watchdog_and_system_reset watchdog_and_system_reset_properties #(.TICK_DIV(TICK_DIV)) i_props (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .timeout_output(timeout_output), .logic_output(logic_output),
  .system_reset_n(system_reset_n), .system_reset_oe(system_reset_oe)
);
`default_nettype wire

// ==== sim/watchdog_and_system_reset_bench.sv ====
`default_nettype none
module watchdog_and_system_reset_bench
  import wdog_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin n_fail++; \
    $display("unexpected %s: expected %0h, seen %0h", n, e, g); end end
  // ****************
  // Stimulus and scoreboard
  // ****************
  // Short tick keeps every ms figure a few cycles long
  localparam int DIV = 8;
  logic aclk = 1'b0, aresetn = 1'b0, host_run = 1'b0, lo_seen = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, general_input = 8'h00, host_gap = 8'h0A;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [23:0] rail_pg_on = 24'h0, rail_below_pg_off = 24'h0;
  logic awready, wready, bvalid, arready, rvalid, keepalive_input, irq;
  logic timeout_output, logic_output, system_reset_n, system_reset_oe, rst_prev, to_prev;
  logic [1:0] bresp, rresp, gb, qb[$];
  logic [33:0] got, qr[$];
  int n_fail = 0, total_checks = 0, cyc = 0, n_fall = 0, to_cnt = 0, n, c0;
  int seed = 32'h0F553D71;
  initial forever #12.5 aclk = ~aclk;
  watchdog_and_system_reset #(.TICK_DIV(DIV)) i_watchdog_and_system_reset (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .keepalive_input(keepalive_input), .general_input(general_input),
    .rail_pg_on(rail_pg_on), .rail_below_pg_off(rail_below_pg_off),
    .timeout_output(timeout_output), .logic_output(logic_output),
    .system_reset_n(system_reset_n), .system_reset_oe(system_reset_oe), .irq(irq));
  keepalive_host i_keepalive_host (.aclk(aclk), .run(host_run), .gap(host_gap),
    .system_reset_n(system_reset_n), .keepalive_input(keepalive_input));
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (rvalid && rready)
    begin
      got = qr.pop_front();
      `CHK("read", got, {rresp, rdata})
    end
    if (bvalid && bready)
    begin
      gb = qb.pop_front();
      `CHK("bresp", gb, bresp)
    end
    n_fall += (rst_prev && !system_reset_n);
    to_cnt += (!to_prev && timeout_output);
    lo_seen |= logic_output;
    rst_prev = system_reset_n;
    to_prev = timeout_output;
    if (cyc == 20000)
    begin
      n_fail++;
      stop_test();
    end
  end
  task automatic clk(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    qb.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        bready <= 1'b0;
    end
    while (awvalid || wvalid || bready);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
    qr.push_back({r, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        rready <= 1'b0;
    end
    while (arvalid || rready);
  endtask
  task automatic wait_rst(input logic v, output int c);
    for (c = 0; system_reset_n !== v; c++)
      @(posedge aclk);
  endtask
  initial
  begin
    clk(10);
    aresetn <= 1'b1;
    clk(1);
    rd(OFS_CTRL, CTRL_RST);
    rd(OFS_PERIOD, 32'(PERIOD_RST));
    rd(OFS_PULSE, 32'(PULSE_RST));
    rd(OFS_RAIL, 32'(RAIL_RST));
    rd(OFS_GPI, 32'(GPI_RST));
    rd(OFS_KICK, 32'h0);
    rd(OFS_IRQ_MASK, 32'(MASK_RST));
    rd(8'h40, 32'h0, RESP_DECERR);
    wr(8'h40, 32'hFFFFFFFF, RESP_DECERR);
    `CHK("released", 1'b1, system_reset_n)
    wr(OFS_PERIOD, 32'h0);
    rd(OFS_PERIOD, 32'h1);
    wr(OFS_PERIOD, 32'h3FFFF);
    rd(OFS_PERIOD, 32'h3F000);
    wr(OFS_PULSE, 32'h7FFF);
    rd(OFS_PULSE, 32'h7E00);
    wr(OFS_PULSE, 32'h2);
    // Random levels on unselected rails and inputs must not matter
    rail_pg_on <= 24'($random(seed)) & 24'hFFFFFE;
    rail_below_pg_off <= 24'($random(seed)) & 24'hFFFFFE;
    general_input <= 8'($random(seed)) & 8'hFE;
    wr(OFS_RAIL, 32'h1);
    wr(OFS_GPI, 32'h1);
    wr(OFS_CTRL, 32'h3 << CTRL_DELAY_LSB);
    clk(60);
    `CHK("held", 1'b0, system_reset_n)
    rail_pg_on[0] <= 1'b1;
    general_input[0] <= 1'b1;
    wait_rst(1'b1, n);
    `CHK("delay", 1'b1, n >= 3 * DIV && n <= 4 * DIV + 4)
    for (int k = 0; k < 2; k++)
    begin
      general_input[0] <= (k == 1);
      rail_below_pg_off[0] <= (k == 1);
      clk(3);
      `CHK("drop", 1'b0, system_reset_n)
      general_input[0] <= 1'b1;
      rail_below_pg_off[0] <= 1'b0;
      wait_rst(1'b1, n);
    end
    c0 = n_fall;
    wr(OFS_GPI, 32'h1);
    wait_rst(1'b1, n);
    `CHK("reconfig", 1'b1, n_fall > c0)
    wr(OFS_CTRL, 32'h1 << CTRL_PULSE_MODE);
    wait_rst(1'b1, n);
    `CHK("pulse", 1'b1, n >= DIV - 4 && n <= 2 * DIV + 4)
    general_input[0] <= 1'b0;
    clk(8);
    `CHK("pulse hold", 1'b1, system_reset_n)
    general_input[0] <= 1'b1;
    wr(OFS_PERIOD, 32'h3);
    wr(OFS_IRQ_MASK, 32'h1);
    host_run <= 1'b1;
    wr(OFS_CTRL, 32'h1);
    wait_rst(1'b1, n);
    wr(OFS_IRQ_STAT, 32'h7);
    c0 = to_cnt;
    clk(150);
    `CHK("kept alive", c0, to_cnt)
    host_run <= 1'b0;
    lo_seen = 1'b0;
    clk(50);
    `CHK("timeout", 1'b1, to_cnt > c0)
    `CHK("logic out", 1'b1, lo_seen)
    `CHK("irq", 1'b1, irq)
    rd(OFS_IRQ_STAT, 32'h1);
    wr(OFS_IRQ_MASK, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    wr(OFS_IRQ_MASK, 32'h1);
    `CHK("irq unmasked", 1'b1, irq)
    wr(OFS_IRQ_STAT, 32'h1);
    `CHK("irq cleared", 1'b0, irq)
    rd(OFS_STATUS, 32'h448);
    wr(OFS_KICK, 32'h1);
    rd(OFS_STATUS, 32'h444);
    clk(50);
    rd(OFS_STATUS, 32'h448);
    host_gap <= 8'h00;
    host_run <= 1'b1;
    clk(1);
    host_run <= 1'b0;
    clk(6);
    rd(OFS_STATUS, 32'h444);
    host_gap <= 8'h28;
    host_run <= 1'b1;
    for (int t = 0; t < 2; t++)
    begin
      wr(OFS_CTRL, t ? 32'hD : 32'h5);
      wait_rst(1'b1, n);
      lo_seen = 1'b0;
      wait_rst(1'b0, n);
      wait_rst(1'b1, n);
      `CHK("wd reset", 1'b1, n >= DIV - 1 && n <= 2 * DIV + 4)
      `CHK("no logic out", 1'b0, lo_seen)
    end
    host_gap <= 8'h0A;
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h1 | (32'h1 << CTRL_START_LSB));
    wait_rst(1'b1, n);
    rd(OFS_STATUS, 32'h442);
    clk(700);
    rd(OFS_STATUS, 32'h442);
    clk(120);
    rd(OFS_STATUS, 32'h444);
    host_run <= 1'b0;
    aresetn <= 1'b0;
    clk(3);
    `CHK("por", 1'b0, system_reset_n)
    aresetn <= 1'b1;
    clk(1);
    rd(OFS_CTRL, CTRL_RST);
    wait_rst(1'b1, n);
    `CHK("re-release", 1'b1, system_reset_n)
    stop_test();
  end
endmodule
`default_nettype wire
